// >>> verilog/fmc_pkg.sv
package fmc_pkg;

  // one lane: 64-bit words, one keep bit per byte
  localparam int FLOW_DATA_W = 64;
  localparam int FLOW_KEEP_W = 8;
  localparam int CTRL_DATA_W = 64;
  localparam int BLKNO_W     = 4;
  localparam int PAYLOAD_W   = 56;
  localparam int ERR_CNT_W   = 8;
  localparam int LFSR_W      = 16;

  localparam logic [BLKNO_W-1:0]     CTRL_ZERO_FIELD = 4'h0;
  localparam logic [BLKNO_W-1:0]     CTRL_BLKNO_MAX  = 4'h8;
  localparam logic [PAYLOAD_W-1:0]   CTRL_PAYLOAD    = 56'h5a_c3_96_3c_a5_0f_f0;
  localparam logic [ERR_CNT_W-1:0]   ERR_CNT_MAX     = 8'hff;
  localparam logic [LFSR_W-1:0]      LFSR_SEED       = 16'hace1;
  localparam logic [FLOW_KEEP_W-1:0] FLOW_LAST_KEEP  = 8'hff;

  // buffer in the flow-message path
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W     = FLOW_DATA_W + FLOW_KEEP_W + 1;

  // generator pacing: message length in words, gaps in core_clk cycles
  localparam logic [3:0] MSG_WORDS = 4'h4;
  localparam logic [3:0] FLOW_GAP  = 4'h3;
  localparam logic [3:0] CTRL_GAP  = 4'h5;

  typedef enum logic {FMC_GAP, FMC_SEND} fmc_flow_state_t;

  // x^16 + x^14 + x^13 + x^11 fibonacci step
  function automatic logic [LFSR_W-1:0] fmc_lfsr_next(input logic [LFSR_W-1:0] cur);
    return {cur[LFSR_W-2:0], cur[15] ^ cur[13] ^ cur[12] ^ cur[10]};
  endfunction

  function automatic logic [FLOW_DATA_W-1:0] fmc_flow_word(input logic [LFSR_W-1:0] cur);
    return {4{cur}};
  endfunction

endpackage

// >>> verilog/fmc_link_if.sv
interface fmc_link_if
  import fmc_pkg::*;
(
  input wire logic coreClk
);
  logic [FLOW_DATA_W-1:0] flowData;
  logic [FLOW_KEEP_W-1:0] flowKeep;
  logic                   flowValid;
  logic                   flowLast;
  logic                   flowReady;
  logic [CTRL_DATA_W-1:0] ctrlData;
  logic                   ctrlValid;
  logic                   channelUp;

  modport src (
    output flowData,
    output flowKeep,
    output flowValid,
    output flowLast,
    input  flowReady,
    output ctrlData,
    output ctrlValid,
    output channelUp
  );

  modport chk (
    input  flowData,
    input  flowKeep,
    input  flowValid,
    input  flowLast,
    output flowReady,
    input  ctrlData,
    input  ctrlValid,
    input  channelUp
  );
endinterface

// >>> verilog/fmc_checker.sv
module fmc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             coreClk,
  input  wire logic             sysRst,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != FULL_CNT);
  assign outValid = (count_q != '0);
  assign outData  = mem_q[rdPtr_q];
  assign push     = inValid & inReady & ~flush;
  assign pop      = outValid & outReady & ~flush;

  always_ff @(posedge coreClk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge coreClk) begin
    if (sysRst || flush) begin
      wrPtr_q <= '0;
    end else if (push) begin
      wrPtr_q <= (wrPtr_q == LAST_IDX) ? '0 : wrPtr_q + 1'b1;
    end
  end

  always_ff @(posedge coreClk) begin
    if (sysRst || flush) begin
      rdPtr_q <= '0;
    end else if (pop) begin
      rdPtr_q <= (rdPtr_q == LAST_IDX) ? '0 : rdPtr_q + 1'b1;
    end
  end

  always_ff @(posedge coreClk) begin
    if (sysRst || flush) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + 1'b1;
    end else if (pop && !push) begin
      count_q <= count_q - 1'b1;
    end
  end
endmodule

module fmc_checker
  import fmc_pkg::*;
(
  input  wire logic                 coreClk,
  input  wire logic                 sysRst,
  fmc_link_if.chk                   link,
  input  wire logic                 drainHold,
  output logic [ERR_CNT_W-1:0]      flowErrCount,
  output logic [ERR_CNT_W-1:0]      ctrlErrCount
);
  logic [FIFO_W-1:0]      pushWord;
  logic [FIFO_W-1:0]      popWord;
  logic                   popValid;
  logic                   popReady;
  logic                   pop;
  logic [FLOW_DATA_W-1:0] popData;
  logic [FLOW_KEEP_W-1:0] popKeep;
  logic                   popLast;
  logic [FLOW_DATA_W-1:0] expFlow;
  logic [FLOW_KEEP_W-1:0] byteMiss;
  logic                   flowMiss;
  logic [LFSR_W-1:0]      lfsr_q;
  logic [ERR_CNT_W-1:0]   flowErr_q;
  logic [BLKNO_W-1:0]     blkNo_q;
  logic [CTRL_DATA_W-1:0] expCtrl;
  logic                   ctrlHit;
  logic                   ctrlMiss;
  logic [ERR_CNT_W-1:0]   ctrlErr_q;
  logic                   flowMissHit_q;
  logic                   ctrlMissHit_q;

  // words offered while valid is low never enter the buffer
  assign pushWord = {link.flowLast, link.flowKeep, link.flowData};

  // eight-word buffer holds flow words while the compare is stalled
  fmc_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) fmc_fifo_i (
    .coreClk  (coreClk),
    .sysRst   (sysRst),
    .flush    (~link.channelUp),
    .inValid  (link.flowValid & link.channelUp),
    .inReady  (link.flowReady),
    .inData   (pushWord),
    .outValid (popValid),
    .outReady (popReady),
    .outData  (popWord)
  );

  assign popReady = ~drainHold;
  assign pop      = popValid & popReady & link.channelUp;
  assign {popLast, popKeep, popData} = popWord;
  assign expFlow  = fmc_flow_word(lfsr_q);

  // keep only qualifies the last word of a message
  genvar gi;
  generate
    for (gi = 0; gi < FLOW_KEEP_W; gi++) begin : g_byte
      assign byteMiss[gi] = (~popLast | popKeep[gi]) &
                            (popData[8*gi +: 8] != expFlow[8*gi +: 8]);
    end
  endgenerate

  assign flowMiss = |byteMiss;

  // a miss is registered first, so the compare and the count sit in separate cycles
  always_ff @(posedge coreClk) begin
    if (sysRst) begin
      flowMissHit_q <= 1'b0;
    end else begin
      flowMissHit_q <= pop & flowMiss;
    end
  end

  always_ff @(posedge coreClk) begin
    if (sysRst || !link.channelUp) begin
      lfsr_q <= LFSR_SEED;
    end else if (pop) begin
      lfsr_q <= fmc_lfsr_next(lfsr_q);
    end
  end

  always_ff @(posedge coreClk) begin
    if (sysRst) begin
      flowErr_q <= '0;
    end else if (flowMissHit_q && flowErr_q != ERR_CNT_MAX) begin
      flowErr_q <= flowErr_q + 1'b1;
    end
  end

  assign ctrlHit = link.ctrlValid & link.channelUp;
  assign expCtrl = {CTRL_ZERO_FIELD, blkNo_q, CTRL_PAYLOAD};
  assign ctrlMiss = (link.ctrlData != expCtrl);

  // a control word is judged in the cycle it shows; nothing of it is buffered
  always_ff @(posedge coreClk) begin
    if (sysRst) begin
      ctrlMissHit_q <= 1'b0;
    end else begin
      ctrlMissHit_q <= ctrlHit & ctrlMiss;
    end
  end

  always_ff @(posedge coreClk) begin
    if (sysRst || !link.channelUp) begin
      blkNo_q <= '0;
    end else if (ctrlHit) begin
      blkNo_q <= (blkNo_q == CTRL_BLKNO_MAX) ? '0 : blkNo_q + 1'b1;
    end
  end

  always_ff @(posedge coreClk) begin
    if (sysRst) begin
      ctrlErr_q <= '0;
    end else if (ctrlMissHit_q && ctrlErr_q != ERR_CNT_MAX) begin
      ctrlErr_q <= ctrlErr_q + 1'b1;
    end
  end

  assign flowErrCount = flowErr_q;
  assign ctrlErrCount = ctrlErr_q;
endmodule

// >>> verilog/fmc_source.sv
module fmc_source
  import fmc_pkg::*;
(
  input  wire logic coreClk,
  input  wire logic sysRst,
  fmc_link_if.src   link,
  input  wire logic linkUp,
  input  wire logic injectFlowErr,
  input  wire logic injectCtrlErr
);
  fmc_flow_state_t        state_q;
  logic                   chanUp_q;
  logic [LFSR_W-1:0]      lfsr_q;
  logic [3:0]             wordCnt_q;
  logic [3:0]             flowGap_q;
  logic                   flowErrPend_q;
  logic                   flowXfer;
  logic                   lastWord;
  logic [3:0]             ctrlGap_q;
  logic [BLKNO_W-1:0]     blkNo_q;
  logic                   ctrlValid_q;
  logic [CTRL_DATA_W-1:0] ctrlData_q;

  always_ff @(posedge coreClk) begin
    if (sysRst) begin
      chanUp_q <= 1'b0;
    end else begin
      chanUp_q <= linkUp;
    end
  end

  assign link.channelUp = chanUp_q;
  assign lastWord       = (wordCnt_q == MSG_WORDS - 4'h1);
  assign flowXfer       = link.flowValid & link.flowReady;

  // a word's lfsr pattern is held until the checker's buffer takes it; a fault requested meanwhile flips its bit 0
  assign link.flowValid = (state_q == FMC_SEND);
  assign link.flowLast  = link.flowValid & lastWord;
  assign link.flowKeep  = link.flowLast ? FLOW_LAST_KEEP : '0;
  assign link.flowData  = fmc_flow_word(lfsr_q) ^ {{(FLOW_DATA_W-1){1'b0}}, flowErrPend_q};

  always_ff @(posedge coreClk) begin
    if (sysRst || !chanUp_q) begin
      state_q   <= FMC_GAP;
      wordCnt_q <= '0;
      flowGap_q <= FLOW_GAP;
    end else begin
      case (state_q)
        FMC_GAP: begin
          if (flowGap_q == '0) begin
            state_q <= FMC_SEND;
          end else begin
            flowGap_q <= flowGap_q - 4'h1;
          end
        end
        FMC_SEND: begin
          if (flowXfer) begin
            wordCnt_q <= lastWord ? '0 : wordCnt_q + 4'h1;
            if (lastWord) begin
              state_q   <= FMC_GAP;
              flowGap_q <= FLOW_GAP;
            end
          end
        end
        default: begin
          state_q <= FMC_GAP;
        end
      endcase
    end
  end

  always_ff @(posedge coreClk) begin
    if (sysRst || !chanUp_q) begin
      lfsr_q <= LFSR_SEED;
    end else if (flowXfer) begin
      lfsr_q <= fmc_lfsr_next(lfsr_q);
    end
  end

  // a requested fault corrupts the next word handed over
  always_ff @(posedge coreClk) begin
    if (sysRst) begin
      flowErrPend_q <= 1'b0;
    end else if (injectFlowErr) begin
      flowErrPend_q <= 1'b1;
    end else if (flowXfer) begin
      flowErrPend_q <= 1'b0;
    end
  end

  always_ff @(posedge coreClk) begin
    if (sysRst || !chanUp_q) begin
      ctrlGap_q   <= CTRL_GAP;
      blkNo_q     <= '0;
      ctrlValid_q <= 1'b0;
      ctrlData_q  <= '0;
    end else if (ctrlGap_q == '0) begin
      ctrlGap_q   <= CTRL_GAP;
      ctrlValid_q <= 1'b1;
      ctrlData_q  <= {CTRL_ZERO_FIELD, blkNo_q, CTRL_PAYLOAD} ^
                     {{(CTRL_DATA_W-1){1'b0}}, injectCtrlErr};
      blkNo_q     <= (blkNo_q == CTRL_BLKNO_MAX) ? '0 : blkNo_q + 1'b1;
    end else begin
      ctrlGap_q   <= ctrlGap_q - 4'h1;
      ctrlValid_q <= 1'b0;
    end
  end

  assign link.ctrlValid = ctrlValid_q;
  assign link.ctrlData  = ctrlData_q;
endmodule

// >>> tb/fmc_link_sva.sv
module fmc_link_sva
  import fmc_pkg::*;
(
  input wire logic                   coreClk,
  input wire logic                   sysRst,
  input wire logic [FLOW_DATA_W-1:0] flowData,
  input wire logic [FLOW_KEEP_W-1:0] flowKeep,
  input wire logic                   flowValid,
  input wire logic                   flowLast,
  input wire logic                   flowReady,
  input wire logic [CTRL_DATA_W-1:0] ctrlData,
  input wire logic                   ctrlValid,
  input wire logic                   channelUp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge coreClk);
  endclocking
  default disable iff (sysRst);

  // a non-final block number sent while the channel stays up
  sequence s_blk_sent;
    ctrlValid && channelUp && ctrlData[59:56] != CTRL_BLKNO_MAX;
  endsequence
  sequence s_up_gap;
    channelUp [*5];
  endsequence

  property p_ctrl_zero;
    ctrlValid |-> ctrlData[63:60] == CTRL_ZERO_FIELD;
  endproperty
  property p_ctrl_pulse;
    ctrlValid |=> !ctrlValid;
  endproperty
  property p_blk_range;
    ctrlValid |-> ctrlData[59:56] <= CTRL_BLKNO_MAX;
  endproperty
  property p_blk_next;
    s_blk_sent ##1 s_up_gap |=>
      ctrlValid && ctrlData[59:56] == $past(ctrlData[59:56], 6) + 4'h1;
  endproperty
  property p_keep_last;
    flowValid && flowLast |-> flowKeep == FLOW_LAST_KEEP;
  endproperty
  property p_keep_mid;
    flowValid && !flowLast |-> flowKeep == 8'h00;
  endproperty
  property p_flow_hold;
    flowValid && !flowReady && channelUp |=>
      flowValid && $stable(flowData) && $stable(flowLast);
  endproperty
  property p_flow_pattern;
    flowValid |-> flowData[63:48] == flowData[47:32] && flowData[47:32] == flowData[31:16];
  endproperty
  property p_rst_state;
    $fell(sysRst) |-> flowReady && !flowValid && !ctrlValid && !channelUp;
  endproperty

  a_ctrl_zero: assert property (p_ctrl_zero)
    else $error("control word zero field wrong");
  a_ctrl_pulse: assert property (p_ctrl_pulse)
    else $error("control valid too long");
  a_blk_range: assert property (p_blk_range)
    else $error("block number too big");
  a_blk_next: assert property (p_blk_next)
    else $error("block number not stepped");
  a_keep_last: assert property (p_keep_last)
    else $error("keep wrong on last word");
  a_keep_mid: assert property (p_keep_mid)
    else $error("keep set on inner word");
  a_flow_hold: assert property (p_flow_hold)
    else $error("flow word dropped on stall");
  a_flow_pattern: assert property (p_flow_pattern)
    else $error("flow word not lfsr pattern");
  a_rst_state: assert property (p_rst_state)
    else $error("state not cleared by reset");
endmodule

// >>> tb/tb.sv
module tb
  import fmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 coreClk;
  logic                 sysRst;
  logic                 linkUp;
  logic                 injectFlowErr;
  logic                 injectCtrlErr;
  logic                 drainHold;
  logic [ERR_CNT_W-1:0] flowErrCount;
  logic [ERR_CNT_W-1:0] ctrlErrCount;
  int                   errTotal;
  int                   testsRun;

  fmc_link_if fmc_link_if_i (.coreClk(coreClk));
  fmc_source fmc_source_i (.coreClk(coreClk), .sysRst(sysRst), .link(fmc_link_if_i.src),
    .linkUp(linkUp), .injectFlowErr(injectFlowErr), .injectCtrlErr(injectCtrlErr));
  fmc_checker fmc_checker_i (.coreClk(coreClk), .sysRst(sysRst), .link(fmc_link_if_i.chk),
    .drainHold(drainHold), .flowErrCount(flowErrCount), .ctrlErrCount(ctrlErrCount));
  fmc_link_sva fmc_link_sva_i (.coreClk(coreClk), .sysRst(sysRst),
    .flowData(fmc_link_if_i.flowData), .flowKeep(fmc_link_if_i.flowKeep),
    .flowValid(fmc_link_if_i.flowValid), .flowLast(fmc_link_if_i.flowLast),
    .flowReady(fmc_link_if_i.flowReady), .ctrlData(fmc_link_if_i.ctrlData),
    .ctrlValid(fmc_link_if_i.ctrlValid), .channelUp(fmc_link_if_i.channelUp));

  always #50 coreClk = ~coreClk;

  task automatic cyc(input int n);
    repeat (n) @(posedge coreClk);
    #1;
  endtask

  task automatic chk(input logic [ERR_CNT_W-1:0] act, input logic [ERR_CNT_W-1:0] exp,
                     input string msg);
    testsRun++;
    if (act !== exp) begin
      errTotal++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, act, exp);
    end
  endtask

  task automatic flow_err;
    injectFlowErr = 1'b1;
    cyc(1);
    injectFlowErr = 1'b0;
  endtask

  task automatic wait_ctrl;
    int n;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (fmc_link_if_i.ctrlValid !== 1'b1 && n < 20);
    if (fmc_link_if_i.ctrlValid !== 1'b1) begin
      errTotal++;
      $display("wrong value at %0t: no control word seen", $time);
    end
  endtask

  // corrupts exactly one control word: raised after one build, dropped after the next
  task automatic ctrl_err_once;
    wait_ctrl();
    injectCtrlErr = 1'b1;
    wait_ctrl();
    injectCtrlErr = 1'b0;
  endtask

  task automatic conclude;
    if (errTotal == 0 && testsRun > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    coreClk = 1'b0;
    sysRst = 1'b1;
    linkUp = 1'b0;
    injectFlowErr = 1'b0;
    injectCtrlErr = 1'b0;
    drainHold = 1'b0;
    errTotal = 0;
    testsRun = 0;
    cyc(8);
    sysRst = 1'b0;
    linkUp = 1'b1;
    cyc(200);
    chk(flowErrCount, 8'h00, "clean flow");
    chk(ctrlErrCount, 8'h00, "clean control");
    flow_err();
    cyc(30);
    chk(flowErrCount, 8'h01, "one flow miss");
    ctrl_err_once();
    cyc(10);
    chk(ctrlErrCount, 8'h01, "one control miss");
    drainHold = 1'b1;
    cyc(40);
    chk({7'h00, fmc_link_if_i.flowReady}, 8'h00, "buffer full");
    drainHold = 1'b0;
    cyc(40);
    chk(flowErrCount, 8'h01, "after stall");
    linkUp = 1'b0;
    cyc(20);
    linkUp = 1'b1;
    cyc(200);
    chk(flowErrCount, 8'h01, "flow after resync");
    chk(ctrlErrCount, 8'h01, "control after resync");
    injectCtrlErr = 1'b1;
    repeat (270) begin
      flow_err();
      cyc(7);
    end
    injectCtrlErr = 1'b0;
    cyc(30);
    chk(flowErrCount, ERR_CNT_MAX, "flow saturated");
    chk(ctrlErrCount, ERR_CNT_MAX, "control saturated");
    sysRst = 1'b1;
    cyc(2);
    sysRst = 1'b0;
    cyc(1);
    chk(flowErrCount, 8'h00, "flow cleared");
    chk(ctrlErrCount, 8'h00, "control cleared");
    cyc(150);
    chk(flowErrCount, 8'h00, "flow after second reset");
    chk(ctrlErrCount, 8'h00, "control after second reset");
    conclude();
  end

  initial begin
    repeat (10000) @(posedge coreClk);
    errTotal++;
    conclude();
  end
endmodule
